// file: bench/dual_compare_pulse_generator_props.sv
/* checker for the pulse generator ports.
   assumes it is bound to the top module from the bench top. */
`timescale 1ns/1ns
module pulse_gen_props (
  input wire clk,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire compare_output_pin,
  input wire compare_event_flag
);
  reg wr_q, done_q;
  reg [7:0] adr_q;
  reg [2:0] mode_q;
  wire act = hsel && hready && htrans[1];
  wire wr_ctl = wr_q && adr_q == 8'h00;
  wire clr_now = wr_q && adr_q == 8'h14 && hwdata[0];
  // follow write data phases, the mode written last and the single pulse end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= 1'b0;
      adr_q <= 8'h00;
      mode_q <= 3'h0;
      done_q <= 1'b0;
    end else begin
      wr_q <= act && hwrite && hsize == 3'b010 && haddr[31:8] == 24'h0;
      adr_q <= haddr[7:0];
      mode_q <= wr_ctl ? hwdata[2:0] : mode_q;
      done_q <= !wr_ctl && (done_q || (mode_q == 3'h4 && $rose(compare_event_flag)));
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence restart_s;
    wr_ctl && (hwdata[2:0] == 3'h4 || (hwdata[2:0] == 3'h5 && mode_q != 3'h5));
  endsequence
  sequence pulse_end_s;
    $fell(compare_output_pin) && !$past(wr_ctl) && mode_q != 3'h0;
  endsequence
  bus_ok_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  unmapped_zero_a: assert property (act && !hwrite && haddr[31:5] != 27'h0 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  flag_fall_a: assert property ($rose(compare_event_flag) |-> $fell(compare_output_pin))
    else $error("flag rose without falling pin");
  fall_flag_a: assert property (pulse_end_s |-> compare_event_flag)
    else $error("falling pin left flag low");
  flag_hold_a: assert property (compare_event_flag && !clr_now |=> compare_event_flag)
    else $error("flag dropped without clear");
  flag_clear_a: assert property (clr_now && !compare_output_pin |=> !compare_event_flag)
    else $error("flag not cleared");
  entry_low_a: assert property (restart_s |=> !compare_output_pin)
    else $error("pin not low on mode entry");
  off_low_a: assert property (mode_q != 3'h4 && mode_q != 3'h5 |=> !compare_output_pin)
    else $error("pin high while off");
  single_once_a: assert property (done_q |-> !compare_output_pin)
    else $error("second pulse in single mode");
endmodule

// file: bench/dual_compare_pulse_generator_tb_top.sv
/* bench top: drives the pulse generator over ahb-lite, watches the pin
   through the load model, checks pulses and registers. assumes 10 mhz. */
`timescale 1ns/1ns
module dual_compare_pulse_generator_tb_top;
  localparam [31:0] P = 32'd19;
  reg clk, rst, hsel, hwrite, clr;
  reg [31:0] haddr, hwdata, s, d;
  reg [1:0] htrans;
  reg [2:0] hsize;
  wire hreadyout, hresp, pin, flag;
  wire [31:0] hrdata;
  wire [7:0] rises, falls;
  wire [15:0] width;
  integer mismatches, checks, i;
  dual_compare_pulse_generator dual_compare_pulse_generator_inst (.clk(clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ext_tick(1'b0), .ext_sync(1'b0), .compare_output_pin(pin),
    .compare_event_flag(flag));
  pulse_load_model pulse_load_model_inst (.clk(clk), .clr(clr), .pin(pin),
    .rises(rises), .falls(falls), .width(width));
  function [31:0] xs(input [31:0] v);
    begin
      xs = v ^ (v << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
    end
  endfunction
  // expected {rose, fell, flag} for the continuous mode
  function [31:0] want(input [31:0] a, input [31:0] b);
    reg r;
    begin
      r = a <= P && (a != 0 || b != 0);
      want = {29'h0, r, r && b <= P, r && b <= P};
    end
  endfunction
  task summarize;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  // wait for hready at the next edges, bounded
  task hs;
    integer n;
    begin
      n = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1) begin
        n = n + 1;
        if (n > 50) begin
          mismatches = mismatches + 1;
          summarize;
        end
        @(posedge clk);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] wd);
    begin
      hwrite <= w;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hs;
      htrans <= 2'b00;
      hwdata <= wd;
      hs;
      d = hrdata;
    end
  endtask
  task soak;
    begin
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (70) @(posedge clk);
    end
  endtask
  // one case: program both values, timer one as sync, then let it run
  task run(input [2:0] m, input [31:0] a, input [31:0] b);
    begin
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h18, 32'h0);
      bus(1'b1, 8'h14, 32'h1);
      bus(1'b1, 8'h08, a);
      bus(1'b1, 8'h0c, b);
      bus(1'b1, 8'h04, 32'h0b);
      bus(1'b1, 8'h1c, P);
      bus(1'b1, 8'h00, {19'h0, 3'h7, 7'h0, m});
      soak;
      bus(1'b1, 8'h18, 32'h1);
      repeat (70) @(posedge clk);
      if (m == 3'h5) chk({29'h0, rises != 8'h0, falls != 8'h0, flag}, want(a, b));
      if (m == 3'h5 && a < b && b <= P) chk({16'h0, width}, b - a);
      $display("case mode %0d values %0d %0d done", m, a, b);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rst, hsel, hwrite, clr, htrans, hsize} = 9'h100;
    {haddr, hwdata, d} = 96'h0;
    {mismatches, checks, s} = {32'd0, 32'd0, 32'd19};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    hsel <= 1'b1;
    hsize <= 3'b010;
    @(posedge clk);
    bus(1'b0, 8'h04, 32'h0);
    chk(d, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    chk(d, 32'h0);
    run(3'h5, 8, 14);
    run(3'h5, 4, 19);
    run(3'h5, 5, 25);
    run(3'h5, 25, 30);
    run(3'h5, 0, 0);
    run(3'h5, 12, 4);
    run(3'h5, 7, 7);
    run(3'h5, 0, 9);
    for (i = 0; i < 4; i = i + 1) begin
      s = xs(s);
      run(3'h5, {27'h0, s[4:0]}, {27'h0, s[12:8]});
    end
    run(3'h4, 3, 8);
    chk({16'h0, rises, falls}, 32'h0101);
    bus(1'b1, 8'h00, 32'h1c04);
    soak;
    chk({16'h0, rises, falls}, 32'h0101);
    bus(1'b0, 8'h14, 32'h0);
    chk(d, 32'h1);
    bus(1'b1, 8'h14, 32'h1);
    bus(1'b0, 8'h14, 32'h0);
    chk(d, 32'h0);
    bus(1'b1, 8'h00, 32'h0);
    @(posedge clk);
    bus(1'b0, 8'h10, 32'h0);
    chk(d, 32'h0);
    summarize;
  end
endmodule
bind dual_compare_pulse_generator pulse_gen_props pulse_gen_props_inst (.clk(clk), .rst(rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .compare_output_pin(compare_output_pin),
  .compare_event_flag(compare_event_flag));

// file: bench/pulse_load_model.sv
/* load model: the external load on the compare pin; counts edges and
   times the last high pulse. assumes the pin is sampled on clk. */
`timescale 1ns/1ns
module pulse_load_model (
  input wire clk,
  input wire clr,
  input wire pin,
  output reg [7:0] rises,
  output reg [7:0] falls,
  output reg [15:0] width
);
  reg last;
  reg [15:0] cnt;
  // count edges and the high time in cycles
  always @(posedge clk) begin
    last <= pin;
    cnt <= pin ? cnt + 16'h0001 : 16'h0000;
    if (!pin && last) width <= cnt;
    if (clr) begin
      rises <= 8'h00;
      falls <= 8'h00;
    end else begin
      rises <= rises + {7'h00, pin && !last};
      falls <= falls + {7'h00, !pin && last};
    end
  end
endmodule

// file: hdl/dual_compare_pulse_generator.v
/*
  dual compare pulse generator: one output compare channel in single and
  continuous pulse modes, with a 16-bit channel timer, a small general
  timer one used as a sync source, and an ahb-lite register slave.

  register map, byte offsets, one aligned word each:
    0x00 first control: mode in [2:0], time base select in [12:10]
    0x04 second control: sync source select in [4:0]
    0x08 first compare value, low half of the word
    0x0c second compare value, low half of the word
    0x10 channel timer, read only
    0x14 status: bit 0 event flag (write one clears), bit 1 pin level
    0x18 general timer one control: bit 0 enable
    0x1c general timer one period

  timing in short:
    - a write lands at the edge that ends its data phase
    - read data are loaded at the address edge and stand in the data phase
    - the channel timer moves on each tick only, a tick being every clock
      for the peripheral clock choice or a rising ext_tick edge otherwise, with no tick while timer one is the sync source and disabled
    - a match is seen on the tick where the timer equals a compare value,
      and the pin changes at that same edge, so one clock after the match
    - the event flag is set at the very edge where the pin falls
    - a sync event between ticks is held until the next tick

  limitations a user must know:
    - only modes 100 and 101 run; every other code behaves like 000
    - compare values are used as written, with no double buffering, so a
      change while running takes effect at the next matching tick
    - the single pulse mode relies on software keeping the second value at
      least one count above the first

  assumes a single 10 mhz clock; ext_tick and ext_sync come from pins
  and are synchronised here. the slave answers with zero wait states.
*/
`timescale 1ns/1ns
`include "pulse_gen_consts.vh"

module dual_compare_pulse_generator #(
  parameter TW = 16
) (
  input wire clk,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire ext_tick,
  input wire ext_sync,
  output reg compare_output_pin,
  output reg compare_event_flag
);

  // pulse sequencer phases:
  // rise waits for the first value match with the pin low,
  // fall waits for the second value match with the pin high,
  // done keeps the pin low after a single pulse until a write of 100, or of 101 from another mode, restarts it
  localparam [1:0] PH_RISE = 2'd0;
  localparam [1:0] PH_FALL = 2'd1;
  localparam [1:0] PH_DONE = 2'd2;
  localparam [TW-1:0] TMAX = {TW{1'b1}};
  localparam [TW-1:0] TONE = {{(TW-1){1'b0}}, 1'b1};

  // software visible state
  reg [2:0] mode_q;
  reg [2:0] tsel_q;
  reg [4:0] ssel_q;
  reg [TW-1:0] cmp1_q;
  reg [TW-1:0] cmp2_q;
  reg t1_en_q;
  reg [TW-1:0] t1_per_q;
  // block state
  reg [TW-1:0] timer_q;
  reg [TW-1:0] t1_cnt_q;
  reg [1:0] phase_q;
  reg seen_reset_q;
  reg sync_pend_q;
  // bus data phase
  reg wr_pend_q;
  reg [4:0] wr_addr_q;
  // pin synchronisers
  reg tick_s1_q, tick_s2_q, tick_s3_q;
  reg sync_s1_q, sync_s2_q, sync_s3_q;


  // decoded bus strobes and the per-tick match terms
  wire addr_ok;
  wire take;
  wire wr_ctrl1;
  wire wr_status;
  wire [2:0] new_mode;
  wire start;
  wire active;
  wire single;
  wire t1_match;
  wire sync_evt;
  wire sync_hit;
  wire tick;
  wire wrap;
  wire both_zero;
  wire rise_hit;
  wire fall_hit;
  wire flag_set;


  // ahb-lite slave always ready, always okay;
  // no register needs more than one cycle, so there are no wait states
  // and no error response: unmapped reads give zero, unmapped writes vanish
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = (haddr[31:5] == 27'h0) && (haddr[1:0] == 2'b00);
  assign take = hsel && hready && htrans[1];


  // address phase capture of writes;
  // only whole-word writes are kept, a narrow write is dropped,
  // and the held address selects the register at the data edge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 5'h00;
    end else begin
      wr_pend_q <= take && hwrite && addr_ok && (hsize == 3'b010);
      wr_addr_q <= haddr[4:0];
    end
  end

  assign wr_ctrl1 = wr_pend_q && (wr_addr_q == `OFS_CTRL1);
  assign wr_status = wr_pend_q && (wr_addr_q == `OFS_STATUS);
  assign new_mode = hwdata[`MODE_MSB:`MODE_LSB];
  // a write of 100 always restarts; 101 only on change of mode
  assign start = wr_ctrl1 && ((new_mode == `MODE_SINGLE) ||
    ((new_mode == `MODE_CONT) && (mode_q != `MODE_CONT)));
  assign active = (mode_q == `MODE_SINGLE) || (mode_q == `MODE_CONT);
  assign single = (mode_q == `MODE_SINGLE);


  // register writes in the data phase;
  // software is expected to turn the channel off before changing values,
  // but nothing here stops a write while the channel runs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= `RST_MODE;
      tsel_q <= `RST_TSEL;
      ssel_q <= `RST_SSEL;
      cmp1_q <= `RST_CMP;
      cmp2_q <= `RST_CMP;
      t1_en_q <= 1'b0;
      t1_per_q <= `RST_T1PER;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        `OFS_CTRL1: begin
          mode_q <= new_mode;
          tsel_q <= hwdata[`TSEL_MSB:`TSEL_LSB];
        end
        `OFS_CTRL2: ssel_q <= hwdata[`SSEL_MSB:`SSEL_LSB];
        `OFS_CMP1: cmp1_q <= hwdata[TW-1:0];
        `OFS_CMP2: cmp2_q <= hwdata[TW-1:0];
        `OFS_T1CTRL: t1_en_q <= hwdata[`T1EN_BIT];
        `OFS_T1PER: t1_per_q <= hwdata[TW-1:0];
        default: t1_en_q <= t1_en_q;
      endcase
    end
  end


  // read data registered at the address phase, valid in the data phase;
  // a read right behind a write to the same register shows the old value,
  // because the write lands only at the end of its data phase
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      hrdata <= 32'h00000000;
      if (addr_ok) begin
        case (haddr[4:0])
          `OFS_CTRL1: begin
            hrdata[`MODE_MSB:`MODE_LSB] <= mode_q;
            hrdata[`TSEL_MSB:`TSEL_LSB] <= tsel_q;
          end
          `OFS_CTRL2: hrdata[`SSEL_MSB:`SSEL_LSB] <= ssel_q;
          `OFS_CMP1: hrdata[TW-1:0] <= cmp1_q;
          `OFS_CMP2: hrdata[TW-1:0] <= cmp2_q;
          `OFS_TIMER: hrdata[TW-1:0] <= timer_q;
          `OFS_STATUS: begin
            hrdata[`FLAG_BIT] <= compare_event_flag;
            hrdata[`PIN_BIT] <= compare_output_pin;
          end
          `OFS_T1CTRL: hrdata[`T1EN_BIT] <= t1_en_q;
          `OFS_T1PER: hrdata[TW-1:0] <= t1_per_q;
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end


  // two-flop synchronisers plus a third stage for edge detection;
  // only the second stage feeds logic, the third only marks a rising edge,
  // and all stages reset low to match the idle level of both pins
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_s3_q <= 1'b0;
      sync_s1_q <= 1'b0;
      sync_s2_q <= 1'b0;
      sync_s3_q <= 1'b0;
    end else begin
      tick_s1_q <= ext_tick;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
      sync_s1_q <= ext_sync;
      sync_s2_q <= sync_s1_q;
      sync_s3_q <= sync_s2_q;
    end
  end


  // general timer one: counts every clock while enabled, period match syncs;
  // its count is kept while disabled, so a restart resumes from there
  assign t1_match = t1_en_q && (t1_cnt_q == t1_per_q);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      t1_cnt_q <= {TW{1'b0}};
    end else if (t1_en_q) begin
      t1_cnt_q <= t1_match ? {TW{1'b0}} : t1_cnt_q + TONE;
    end
  end


  // sync source choice; free-run has none
  assign sync_evt = (ssel_q == `SSEL_FREE) ? 1'b0 :
    (ssel_q == `SSEL_T1) ? t1_match :
    (sync_s2_q && !sync_s3_q);
  assign sync_hit = sync_evt || sync_pend_q;
  // timer clock choice; timer one sync also gates the channel timer
  assign tick = ((tsel_q == `TSEL_PERIPH) ? 1'b1 : (tick_s2_q && !tick_s3_q)) &&
    ((ssel_q != `SSEL_T1) || t1_en_q);
  assign wrap = (timer_q == TMAX);


  // a sync seen between ticks waits for the next tick;
  // the pending bit is dropped while off so no stale sync survives entry
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_pend_q <= 1'b0;
    end else if (!active || tick) begin
      sync_pend_q <= 1'b0;
    end else if (sync_evt) begin
      sync_pend_q <= 1'b1;
    end
  end


  // channel timer: held at zero while off, cleared after sync or wrap;
  // seen_reset_q records a clear since entry, which a zero first value needs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_q <= {TW{1'b0}};
      seen_reset_q <= 1'b0;
    end else if (!active) begin
      timer_q <= {TW{1'b0}};
      seen_reset_q <= 1'b0;
    end else begin
      if (start) begin
        seen_reset_q <= 1'b0;
      end else if (tick && (sync_hit || wrap)) begin
        seen_reset_q <= 1'b1;
      end
      if (tick) begin
        timer_q <= (sync_hit || wrap) ? {TW{1'b0}} : timer_q + TONE;
      end
    end
  end


  // compare matches, taken on timer ticks only;
  // both values zero blocks every edge, so the flag can never be set
  assign both_zero = (cmp1_q == {TW{1'b0}}) && (cmp2_q == {TW{1'b0}});
  // a zero first value only counts once the timer has been cleared
  assign rise_hit = tick && !both_zero && (phase_q == PH_RISE) && (timer_q == cmp1_q) &&
    ((cmp1_q != {TW{1'b0}}) || seen_reset_q);
  assign fall_hit = tick && !both_zero && (phase_q == PH_FALL) &&
    (timer_q == cmp2_q);
  assign flag_set = active && !start && fall_hit;


  // pulse sequencer and output pin;
  // a sync at the second match clears the timer but leaves the fall intact,
  // and a sync between the matches leaves the pin high into the next cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= PH_RISE;
      compare_output_pin <= 1'b0;
    end else if (!active || start) begin
      phase_q <= PH_RISE;
      compare_output_pin <= 1'b0;
    end else begin
      case (phase_q)
        PH_RISE: begin
          if (rise_hit) begin
            phase_q <= PH_FALL;
            compare_output_pin <= 1'b1;
          end
        end
        PH_FALL: begin
          if (fall_hit) begin
            phase_q <= single ? PH_DONE : PH_RISE;
            compare_output_pin <= 1'b0;
          end
        end
        PH_DONE: compare_output_pin <= 1'b0;
        default: begin
          phase_q <= PH_RISE;
          compare_output_pin <= 1'b0;
        end
      endcase
    end
  end


  // sticky event flag, write one to clear; a set in the same cycle wins
  // so that no falling edge is ever lost to a late clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      compare_event_flag <= 1'b0;
    end else if (flag_set) begin
      compare_event_flag <= 1'b1;
    end else if (wr_status && hwdata[`FLAG_BIT]) begin
      compare_event_flag <= 1'b0;
    end
  end

endmodule

// file: hdl/pulse_gen_consts.vh
/*
  constants for the dual compare pulse generator: register offsets,
  field positions, mode codes, select codes and reset values.
  assumes it is included by its bare name from the design file.
*/
`ifndef PULSE_GEN_CONSTS_VH
`define PULSE_GEN_CONSTS_VH

// register byte offsets
`define OFS_CTRL1 5'h00
`define OFS_CTRL2 5'h04
`define OFS_CMP1 5'h08
`define OFS_CMP2 5'h0c
`define OFS_TIMER 5'h10
`define OFS_STATUS 5'h14
`define OFS_T1CTRL 5'h18
`define OFS_T1PER 5'h1c

// field positions
`define MODE_MSB 2
`define MODE_LSB 0
`define TSEL_MSB 12
`define TSEL_LSB 10
`define SSEL_MSB 4
`define SSEL_LSB 0
`define FLAG_BIT 0
`define PIN_BIT 1
`define T1EN_BIT 0

// codes
`define MODE_OFF 3'h0
`define MODE_SINGLE 3'h4
`define MODE_CONT 3'h5
`define TSEL_PERIPH 3'h7
`define SSEL_FREE 5'h00
`define SSEL_T1 5'h0b

// reset values
`define RST_MODE 3'h0
`define RST_TSEL 3'h0
`define RST_SSEL 5'h00
`define RST_CMP 16'h0000
`define RST_T1PER 16'hffff

`endif
